// *** rcl_params.svh ***
// Constants for the reset cause logic: offsets, bit positions, reset values and timing.
`ifndef RCL_PARAMS_SVH
`define RCL_PARAMS_SVH
`define RCL_ADDR_STATUS 4'h0
`define RCL_ADDR_CTRL 4'h4
`define RCL_ADDR_SHADOW 4'h8
`define RCL_BIT_POR 0
`define RCL_BIT_BOR 1
`define RCL_BIT_IDLE 2
`define RCL_BIT_SLEEP 3
`define RCL_BIT_WDT 4
`define RCL_BIT_SOFT 6
`define RCL_BIT_PIN 7
`define RCL_BIT_CM 9
`define RCL_BIT_ILL 14
`define RCL_BIT_TRAP 15
`define RCL_STATUS_MASK 16'hC2DF
`define RCL_STATUS_RST 16'h0003
`define RCL_ILLEGAL_UPPER 8'h3F
`define RCL_TRAP_LVL_LO 4'hD
`define RCL_TRAP_LVL_HI 4'hF
`define RCL_PIN_MIN_NS 200
`define RCL_CLK_NS 40
`define RCL_PIN_CYC ((`RCL_PIN_MIN_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)
`define RCL_NUM_WREG 15
`endif

// *** rcl_pkg.sv ***
// Types shared by the reset cause logic files.
package rcl_pkg;
  typedef struct packed {
    logic sw_reset;
    logic wdt_timeout;
    logic in_sleep;
    logic in_idle;
    logic power_save_sleep;
    logic power_save_idle;
    logic watchdog_clear;
    logic illegal_fetch;
    logic [7:0] fetch_upper;
  } rcl_cpu_s;
  typedef struct packed {
    logic trap_valid;
    logic [3:0] trap_level;
    logic trap_active;
    logic [3:0] active_level;
    logic flow_change;
    logic vector_change;
    logic restricted_target;
  } rcl_flow_s;
  typedef struct packed {
    logic wr_en;
    logic [3:0] wr_idx;
    logic ptr_use;
    logic [3:0] ptr_idx;
  } rcl_wreg_s;
  typedef enum logic [2:0] {
    RCL_IDLE = 3'b001,
    RCL_CYCLE = 3'b010,
    RCL_WAIT = 3'b100
  } rcl_bus_e;
endpackage : rcl_pkg

// *** rcl_pin_filter.sv ***
// Glitch filter for the active-low master reset pin.
`timescale 1ns/1ps
`include "rcl_params.svh"
module rcl_pin_filter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic master_reset_pin_n,
  output logic pin_reset
);
  logic [1:0] sync_r;
  logic [7:0] cnt_r;
  // ************************************************************
  // Synchroniser and low-pulse qualification.
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_r <= 2'h3;
    end else begin
      sync_r <= {sync_r[0], master_reset_pin_n};
    end
  end
  // Short low pulses never reach the count, so glitches are dropped.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      pin_reset <= 1'b0;
    end else if (sync_r[1]) begin
      cnt_r <= 8'h00;
      pin_reset <= 1'b0;
    end else if (cnt_r >= 8'(`RCL_PIN_CYC)) begin
      pin_reset <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : rcl_pin_filter

// *** rcl_reset_cause.sv ***
// Reset cause logic: source detection, system reset and the cause status register.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "rcl_params.svh"
module rcl_reset_cause (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic power_on_reset,
  input wire logic brown_out_reset,
  input wire logic master_reset_pin_n,
  input wire logic watchdog_timeout_async,
  input wire rcl_pkg::rcl_cpu_s cpu_evt,
  input wire rcl_pkg::rcl_flow_s flow_evt,
  input wire rcl_pkg::rcl_wreg_s wreg_evt,
  input wire logic [15:0] pps_live,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output logic system_reset,
  output logic wake_request,
  output logic clock_reinit,
  output logic [14:0] wreg_init_flags
);
  logic pin_reset;
  logic [1:0] wdt_sync_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] shadow_r;
  logic cm_enable_r;
  logic sw_reset_r;
  logic event_reset_r;
  logic [15:0] evt_set;
  logic trap_conflict;
  logic illegal_op;
  logic uninit_use;
  logic security_viol;
  logic cm_mismatch;
  logic wdt_run;
  logic any_reset;
  logic [14:0] wreg_valid_r;
  rcl_pkg::rcl_bus_e bus_state_r;
  logic bus_hit;
  logic [31:0] rdata_nxt;

  // ************************************************************
  // Helpers.
  // ************************************************************
  function automatic logic is_hard_trap(input logic [3:0] lvl);
    is_hard_trap = (lvl >= `RCL_TRAP_LVL_LO) && (lvl <= `RCL_TRAP_LVL_HI);
  endfunction : is_hard_trap

  function automatic logic [15:0] merge_be(input logic [15:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] be);
    merge_be = old_v;
    if (be[0]) begin
      merge_be[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge_be[15:8] = wd[15:8];
    end
  endfunction : merge_be

  // ************************************************************
  // Reset sources.
  // ************************************************************
  rcl_pin_filter u_pin_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .master_reset_pin_n(master_reset_pin_n),
    .pin_reset(pin_reset)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdt_sync_r <= 2'h0;
    end else begin
      wdt_sync_r <= {wdt_sync_r[0], watchdog_timeout_async};
    end
  end

  assign wdt_run = wdt_sync_r[1] && !cpu_evt.in_sleep && !cpu_evt.in_idle;
  assign wake_request = wdt_sync_r[1] && (cpu_evt.in_sleep || cpu_evt.in_idle);

  // A lower-priority hard trap arriving during a higher one is a conflict.
  assign trap_conflict = flow_evt.trap_valid && flow_evt.trap_active &&
                         is_hard_trap(flow_evt.trap_level) &&
                         (flow_evt.trap_level < flow_evt.active_level);
  assign illegal_op = cpu_evt.illegal_fetch ||
                      (cpu_evt.fetch_upper == `RCL_ILLEGAL_UPPER);
  assign security_viol = (flow_evt.flow_change || flow_evt.vector_change) &&
                         flow_evt.restricted_target;
  // The stack pointer is never cleared, so index 15 always counts as written.
  assign uninit_use = wreg_evt.ptr_use && (wreg_evt.ptr_idx != 4'hF) &&
                      !wreg_valid_r[wreg_evt.ptr_idx];
  assign cm_mismatch = cm_enable_r && (pps_live != shadow_r);

  always_comb begin
    evt_set = 16'h0000;
    evt_set[`RCL_BIT_PIN] = pin_reset;
    evt_set[`RCL_BIT_SOFT] = cpu_evt.sw_reset;
    evt_set[`RCL_BIT_WDT] = wdt_run;
    evt_set[`RCL_BIT_TRAP] = trap_conflict;
    evt_set[`RCL_BIT_CM] = cm_mismatch;
    evt_set[`RCL_BIT_ILL] = illegal_op || uninit_use || security_viol;
    evt_set[`RCL_BIT_SLEEP] = cpu_evt.power_save_sleep;
    evt_set[`RCL_BIT_IDLE] = cpu_evt.power_save_idle;
  end

  // ************************************************************
  // System reset generation.
  // ************************************************************
  // The software reset follows cpu_evt.sw_reset one cycle later, lasts as long as it is held, and never touches the clock source.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_reset_r <= 1'b0;
    end else begin
      sw_reset_r <= cpu_evt.sw_reset;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_reset_r <= 1'b0;
    end else begin
      event_reset_r <= trap_conflict || cm_mismatch || illegal_op || uninit_use ||
                       security_viol;
    end
  end

  // The watchdog path bypasses the event register so its reset asserts at once.
  assign any_reset = pin_reset || sw_reset_r || event_reset_r || wdt_run ||
                     power_on_reset || brown_out_reset;
  assign system_reset = any_reset;
  assign clock_reinit = power_on_reset || brown_out_reset;

  // ************************************************************
  // Working register initialization tracking.
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `RCL_NUM_WREG; gi = gi + 1) begin : g_wreg
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          wreg_valid_r[gi] <= 1'b0;
        end else if (any_reset) begin
          wreg_valid_r[gi] <= 1'b0;
        end else if (wreg_evt.wr_en && (wreg_evt.wr_idx == 4'(gi))) begin
          wreg_valid_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate
  assign wreg_init_flags = wreg_valid_r;

  // ************************************************************
  // Cause status register.
  // ************************************************************
  always_comb begin
    status_nxt = status_r;
    if (bus_hit && avs_write && (avs_address == `RCL_ADDR_STATUS)) begin
      status_nxt = merge_be(status_r, avs_writedata, avs_byteenable);
    end
    if (cpu_evt.power_save_sleep || cpu_evt.power_save_idle || cpu_evt.watchdog_clear) begin
      status_nxt[`RCL_BIT_WDT] = 1'b0;
    end
    // Besides software writes and the WDT clear above, only power resets clear flags; other causes accumulate.
    if (brown_out_reset) begin
      status_nxt = status_nxt & 16'h0080;
      status_nxt[`RCL_BIT_BOR] = 1'b1;
    end
    if (power_on_reset) begin
      status_nxt = 16'h0000;
      status_nxt[`RCL_BIT_POR] = 1'b1;
      status_nxt[`RCL_BIT_BOR] = 1'b1;
    end
    // A hardware event in the clearing cycle wins over a software clear.
    status_nxt = (status_nxt | evt_set) & `RCL_STATUS_MASK;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r <= `RCL_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Shadow copy is loaded by software; while armed, any drift of the live value resets.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shadow_r <= 16'h0000;
      cm_enable_r <= 1'b0;
    end else if (bus_hit && avs_write) begin
      if (avs_address == `RCL_ADDR_SHADOW) begin
        shadow_r <= merge_be(shadow_r, avs_writedata, avs_byteenable);
      end
      if ((avs_address == `RCL_ADDR_CTRL) && avs_byteenable[0]) begin
        cm_enable_r <= avs_writedata[0];
      end
    end
  end

  // ************************************************************
  // Avalon-MM slave: one wait cycle from idle, then the answer; a request in the cycle after an answer waits two.
  // ************************************************************
  assign bus_hit = (bus_state_r == rcl_pkg::RCL_CYCLE);
  assign avs_waitrequest = (avs_read || avs_write) && !bus_hit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_state_r <= rcl_pkg::RCL_IDLE;
    end else begin
      case (bus_state_r)
        rcl_pkg::RCL_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_r <= rcl_pkg::RCL_CYCLE;
          end
        end
        rcl_pkg::RCL_CYCLE: begin
          bus_state_r <= rcl_pkg::RCL_WAIT;
        end
        rcl_pkg::RCL_WAIT: begin
          bus_state_r <= rcl_pkg::RCL_IDLE;
        end
        default: begin
          bus_state_r <= rcl_pkg::RCL_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    case (avs_address)
      `RCL_ADDR_STATUS: rdata_nxt = {16'h0000, status_r};
      `RCL_ADDR_CTRL: rdata_nxt = {31'h00000000, cm_enable_r};
      `RCL_ADDR_SHADOW: rdata_nxt = {16'h0000, shadow_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data is registered, so the decode is a cycle ahead of the accept edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if (bus_state_r == rcl_pkg::RCL_IDLE && (avs_read || avs_write)) begin
      avs_readdata <= rdata_nxt;
      avs_response <= ((avs_address == `RCL_ADDR_STATUS) || (avs_address == `RCL_ADDR_CTRL) ||
                       (avs_address == `RCL_ADDR_SHADOW)) ? 2'h0 : 2'h2;
    end
  end
endmodule : rcl_reset_cause

// *** rcl_supervisor.sv ***
// Behavioural supervisory circuit that pulls the reset pin low.
`timescale 1ns/1ps
module rcl_supervisor (
  input wire logic clk_sys,
  input wire logic [7:0] low_cycles,
  input wire logic fire,
  output logic master_reset_pin_n
);
  logic [7:0] count_r = 8'h00;
  always @(posedge clk_sys) begin
    if (fire) begin
      count_r <= low_cycles;
    end else if (count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
    end
  end
  // The pin is tied high between pulses because it has no pull-up of its own.
  assign master_reset_pin_n = (count_r == 8'h00);
endmodule : rcl_supervisor

// *** rcl_reset_cause_chk.sv ***
// Port checker for the reset cause logic.
`timescale 1ns/1ps
module rcl_reset_cause_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic power_on_reset,
  input wire logic brown_out_reset,
  input wire logic master_reset_pin_n,
  input wire logic watchdog_timeout_async,
  input wire rcl_pkg::rcl_cpu_s cpu_evt,
  input wire rcl_pkg::rcl_flow_s flow_evt,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic system_reset,
  input wire logic wake_request,
  input wire logic clock_reinit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  soft_reset_a: assert property (cpu_evt.sw_reset |=> system_reset)
    else $error("soft reset missing");
  clock_kept_a: assert property (!power_on_reset && !brown_out_reset |-> !clock_reinit)
    else $error("clock reinit without power reset");
  illegal_op_a: assert property (cpu_evt.fetch_upper == 8'h3F |=> system_reset)
    else $error("illegal opcode reset missing");
  trap_conflict_a: assert property (flow_evt.trap_valid && flow_evt.trap_active
    && flow_evt.trap_level >= 4'hD && flow_evt.trap_level < flow_evt.active_level |=> system_reset)
    else $error("trap conflict reset missing");
  secure_flow_a: assert property ((flow_evt.flow_change || flow_evt.vector_change)
    && flow_evt.restricted_target |=> system_reset)
    else $error("security reset missing");
  wdt_run_a: assert property ((watchdog_timeout_async && !cpu_evt.in_sleep
    && !cpu_evt.in_idle) [*4] |-> system_reset)
    else $error("watchdog reset missing");
  wdt_wake_a: assert property ((watchdog_timeout_async && cpu_evt.in_sleep) [*4]
    |-> wake_request)
    else $error("watchdog wake missing");
  pin_reset_a: assert property ((!master_reset_pin_n) [*8] |-> ##[0:3] system_reset)
    else $error("pin reset missing");
  bus_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer late");
  unmapped_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'hC
    |-> avs_response == 2'b10 && avs_readdata == 32'h0)
    else $error("unmapped read answer wrong");
endmodule : rcl_reset_cause_chk
bind rcl_reset_cause rcl_reset_cause_chk chk_u (.clk_sys(clk_sys), .rst(rst),
  .power_on_reset(power_on_reset), .brown_out_reset(brown_out_reset),
  .master_reset_pin_n(master_reset_pin_n), .watchdog_timeout_async(watchdog_timeout_async),
  .cpu_evt(cpu_evt), .flow_evt(flow_evt), .avs_address(avs_address), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .system_reset(system_reset), .wake_request(wake_request), .clock_reinit(clock_reinit));

// *** rcl_reset_cause_test.sv ***
// Testbench for the reset cause logic.
`timescale 1ns/1ps
module rcl_reset_cause_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic power_on_reset = 1'b0;
  logic brown_out_reset = 1'b0;
  logic wdt = 1'b0;
  logic fire = 1'b0;
  logic [7:0] low_cycles = 8'h00;
  logic pin_n;
  rcl_pkg::rcl_cpu_s cpu_evt = '0;
  rcl_pkg::rcl_flow_s flow_evt = '{trap_valid: 1'b0, trap_level: 4'hD, trap_active: 1'b1,
    active_level: 4'hE, flow_change: 1'b0, vector_change: 1'b0, restricted_target: 1'b1};
  rcl_pkg::rcl_wreg_s wreg_evt = '{wr_en: 1'b0, wr_idx: 4'h3, ptr_use: 1'b0, ptr_idx: 4'h3};
  logic [15:0] pps_live = 16'h0000;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [1:0] resp;
  logic system_reset;
  logic [14:0] wreg_flags;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [15:0] exp_tab [0:7] = '{16'h0040, 16'h4000, 16'h4000, 16'h4000, 16'h4000,
    16'h8000, 16'h0200, 16'h0010};
  initial forever #20 clk_sys = ~clk_sys;
  rcl_supervisor sup_u (.clk_sys(clk_sys), .low_cycles(low_cycles), .fire(fire),
    .master_reset_pin_n(pin_n));
  rcl_reset_cause dut_u (.clk_sys(clk_sys), .rst(rst), .power_on_reset(power_on_reset),
    .brown_out_reset(brown_out_reset), .master_reset_pin_n(pin_n),
    .watchdog_timeout_async(wdt), .cpu_evt(cpu_evt), .flow_evt(flow_evt),
    .wreg_evt(wreg_evt), .pps_live(pps_live), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .system_reset(system_reset), .wake_request(),
    .clock_reinit(), .wreg_init_flags(wreg_flags));
  // ****
  // Tasks.
  // ****
  task report_and_stop;
    $display("mismatches %0d checks %0d", bad_count, total_checks);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  // Called just after a rising edge; one edge passes after the release before any new request.
  task bus(input logic [3:0] a, input logic w, input logic [15:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {16'h0000, d};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task rd(input logic [3:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 16'h0000, q);
    cmp("readdata", {16'h0000, e}, q);
  endtask : rd
  task wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task drive(input int k, input logic v);
    case (k)
      0: cpu_evt.sw_reset <= v;
      1: cpu_evt.fetch_upper <= v ? 8'h3F : 8'h00;
      2: flow_evt.flow_change <= v;
      3: flow_evt.vector_change <= v;
      4: wreg_evt.ptr_use <= v;
      5: flow_evt.trap_valid <= v;
      6: pps_live <= {15'h0000, v};
      7: wdt <= v;
      8: cpu_evt.watchdog_clear <= v;
      9: cpu_evt.power_save_sleep <= v;
      10: cpu_evt.in_sleep <= v;
      11: fire <= v;
      12: brown_out_reset <= v;
      14: wreg_evt.wr_en <= v;
      15: cpu_evt.power_save_idle <= v;
      16: cpu_evt.illegal_fetch <= v;
      default: power_on_reset <= v;
    endcase
  endtask : drive
  // Twelve idle cycles cover the pin synchroniser and filter before the next read.
  task ev(input int k, input int n);
    @(posedge clk_sys);
    drive(k, 1'b1);
    repeat (n) @(posedge clk_sys);
    drive(k, 1'b0);
    repeat (12) @(posedge clk_sys);
  endtask : ev
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  // ****
  // Sequence.
  // ****
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 16'h0003);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'hC2DF);
    rd(4'hC, 16'h0000);
    cmp("response", 32'h2, {30'h0, resp});
    wr(4'h4, 16'h0001);
    for (int k = 0; k < 8; k++) begin
      wr(4'h0, 16'h0000);
      ev(k, (k == 7) ? 6 : 1);
      rd(4'h0, exp_tab[k]);
    end
    ev(0, 1);
    rd(4'h0, 16'h0050);
    ev(8, 1);
    rd(4'h0, 16'h0040);
    ev(7, 6);
    ev(9, 1);
    rd(4'h0, 16'h0048);
    // Sleep is entered before the time-out and left only after the synchroniser has cleared.
    cpu_evt.in_sleep <= 1'b1;
    ev(7, 6);
    cpu_evt.in_sleep <= 1'b0;
    rd(4'h0, 16'h0048);
    wr(4'h0, 16'h0000);
    ev(14, 1);
    cmp("wreg_init_flags", 32'h0008, {17'h0, wreg_flags});
    ev(4, 1);
    rd(4'h0, 16'h0000);
    ev(16, 1);
    cmp("wreg_init_flags", 32'h0000, {17'h0, wreg_flags});
    ev(15, 1);
    rd(4'h0, 16'h4004);
    wr(4'h0, 16'h0000);
    low_cycles <= 8'h02;
    ev(11, 1);
    rd(4'h0, 16'h0000);
    low_cycles <= 8'h0A;
    ev(11, 1);
    rd(4'h0, 16'h0080);
    wr(4'h0, 16'hC2DF);
    ev(12, 1);
    rd(4'h0, 16'h0082);
    ev(13, 1);
    rd(4'h0, 16'h0003);
    report_and_stop;
  end
endmodule : rcl_reset_cause_test
